// [src/uie_consts.vh]
// uie_consts.vh: constants for the uart interrupt mask, status and dma ready block
// assumes inclusion by bare name from design files
`ifndef UIE_CONSTS_VH
`define UIE_CONSTS_VH
// register addresses (a2..a0)
`define UIE_ADDR_DATA 3'h0
`define UIE_ADDR_MASK 3'h1
`define UIE_ADDR_IDENT 3'h2
`define UIE_ADDR_LCTL 3'h3
`define UIE_ADDR_LINE 3'h5
`define UIE_ADDR_MODEM 3'h6
// reset values
`define UIE_MASK_RESET 8'h00
`define UIE_FCTL_RESET 8'h00
`define UIE_LCTL_RESET 8'h00
// mask field positions
`define UIE_MASK_RX 0
`define UIE_MASK_TX 1
`define UIE_MASK_LS 2
`define UIE_MASK_MS 3
// fifo control field positions
`define UIE_FCTL_EN 0
`define UIE_FCTL_RXRST 1
`define UIE_FCTL_TXRST 2
`define UIE_FCTL_DMA 3
`define UIE_FCTL_TRIG_LO 6
`define UIE_FCTL_TRIG_HI 7
// line control divisor access bit
`define UIE_LCTL_DLAB 7
// identification codes: priority in bits 3..1, bit 0 set means none pending
`define UIE_ID_NONE 4'h1
`define UIE_ID_LS 4'h6
`define UIE_ID_RX 4'h4
`define UIE_ID_TX 4'h2
`define UIE_ID_MS 4'h0
// fifo geometry
`define UIE_FIFO_DEPTH 8
`define UIE_FIFO_AW 3
`define UIE_CNT_W 4
`endif

// [src/uie_fifo.v]
// uie_fifo.v: small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module uie_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // clock and reset
   input wire clk,
   input wire rst,
   input wire flush,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   // fill level
   output reg [AW:0] count
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg not_full;
   reg [AW:0] next_count;
   wire push;
   wire pop;
   // registered so a top-level ready never comes through logic
   assign in_ready = not_full;
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always @* begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end
   always @(posedge clk) begin
      if (rst || flush) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         not_full <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
         not_full <= (next_count != DEPTH[AW:0]);
      end
   end
endmodule // uie_fifo
`default_nettype wire

// [src/uie_channel.v]
// uie_channel.v: one uart channel's interrupt mask, identification, line status
// and dma ready strobes, with an 8-deep receive fifo in the data path.
// assumes: serial engine supplies received characters with error bits, reports
// transmit fifo/holding/shift state, and sets modem change bits; host bus is
// synchronous to clk with one-cycle read and write strobes.
// Behaviour
// - upper four mask bits unused, always read zero
// - mask bit 3 enables interrupt on any modem change bit set
// - mask bit 2 enables interrupt on any line error bit 1..4
// - fifos off: transmit-empty interrupt follows holding register empty
// - fifos on: transmit-empty interrupt needs fifo and holding register empty
// - fifos off: receive interrupt while holding register holds data
// - fifos on: receive interrupt while count at or above trigger level
// - transmit-empty reports priority 3, receive-ready priority 2
// - identification shows receive trigger, clears when count drops below
// - data ready set when a character enters fifo, cleared when empty
// - transmit-empty interrupt cleared by identification read or data write
// - all mask bits clear gives no interrupts; host polls line status
// - line status bit 5 high when transmit fifo empty in fifo mode, holding register empty otherwise
// - line status bit 6 high when transmit fifo, holding and shift register empty
// - line status bit 7 high in fifo mode when any fifo character has an error
// - dma mode 0: transmit ready low while transmit fifo empty in fifo mode, holding register empty otherwise
// - dma mode 0: receive ready low when holding register loaded
// - dma mode 1: transmit ready low while a fifo location is empty
// - dma mode 1: receive interrupt at trigger, fifo keeps filling to full
// - dma mode 1: receive ready low from reaching trigger level until fifo empties
// - masked requests drive the channel's interrupt output
// - fifo mode active when fifo control bit 0 is one
`timescale 1ns/1ps
`default_nettype none
`include "uie_consts.vh"
module uie_channel (
   // clock and reset
   input wire clk,
   input wire rst,
   // host register bus
   input wire cs_n,
   input wire [2:0] addr,
   input wire wr_stb,
   input wire rd_stb,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data,
   // serial engine receive side
   input wire rx_valid,
   output wire rx_ready,
   input wire [7:0] rx_char,
   input wire [3:0] rx_err,
   // serial engine transmit side
   input wire tx_fifo_empty,
   input wire tx_fifo_full,
   input wire tx_hold_empty,
   input wire tx_shift_empty,
   // modem state
   input wire [7:0] modem_status,
   input wire rx_mf_mode,
   // outputs
   output reg channel_irq,
   output reg transmit_ready_n,
   output reg multi_function_pin
);
   localparam CW = `UIE_CNT_W;
   reg [3:0] interrupt_source_mask;
   reg [7:0] fifo_control_register;
   reg [7:0] line_control_register;
   reg tx_pend;
   reg tx_empty_q;
   reg rx_rdy_latch;
   wire [11:0] fifo_out;
   wire fifo_valid;
   wire [CW-1:0] rx_count;
   wire fifo_mode;
   wire dma_mode1;
   wire gen_access;
   wire rd_hit;
   wire pop;
   wire flush;
   wire [3:0] top_err;
   reg [CW-1:0] trig;
   reg [3:0] ident;
   reg [7:0] line_stat;
   reg [`UIE_FIFO_DEPTH-1:0] err_flag;
   wire rx_lvl;
   wire ls_src;
   wire ms_src;
   wire tx_cond;
   wire fifo_err;

   assign fifo_mode = fifo_control_register[`UIE_FCTL_EN];
   assign dma_mode1 = fifo_mode && fifo_control_register[`UIE_FCTL_DMA];
   assign gen_access = !cs_n && !line_control_register[`UIE_LCTL_DLAB];
   // line control stays readable while divisor access is set
   assign rd_hit = rd_stb && !cs_n &&
      (!line_control_register[`UIE_LCTL_DLAB] || addr == `UIE_ADDR_LCTL);
   assign pop = rd_hit && (addr == `UIE_ADDR_DATA) && fifo_valid;
   assign flush = wr_stb && gen_access && (addr == `UIE_ADDR_IDENT) &&
      wr_data[`UIE_FCTL_RXRST];
   assign top_err = fifo_out[11:8];

   // receive fifo holds char plus error bits; engine stalls on rx_ready low
   uie_fifo #(
      .WIDTH(12),
      .DEPTH(`UIE_FIFO_DEPTH),
      .AW(`UIE_FIFO_AW)
   ) u_rx_fifo (
      .clk(clk),
      .rst(rst),
      .flush(flush),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data({rx_err, rx_char}),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_out),
      .count(rx_count)
   );

   // trigger levels scaled to the 8-deep fifo: 1, 2, 4, 7
   always @* begin
      case (fifo_control_register[`UIE_FCTL_TRIG_HI:`UIE_FCTL_TRIG_LO])
         2'h0: trig = 4'h1;
         2'h1: trig = 4'h2;
         2'h2: trig = 4'h4;
         default: trig = 4'h7;
      endcase
   end

   // per-entry error flags shadow the fifo, for the fifo data error bit
   reg [`UIE_FIFO_AW-1:0] ewr;
   reg [`UIE_FIFO_AW-1:0] erd;
   always @(posedge clk) begin
      if (rst || flush) begin
         ewr <= {`UIE_FIFO_AW{1'b0}};
         erd <= {`UIE_FIFO_AW{1'b0}};
      end else begin
         if (rx_valid && rx_ready) begin
            ewr <= ewr + 1'b1;
         end
         if (pop) begin
            erd <= erd + 1'b1;
         end
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < `UIE_FIFO_DEPTH; gi = gi + 1) begin : g_err
         always @(posedge clk) begin
            if (rst || flush) begin
               err_flag[gi] <= 1'b0;
            end else if (rx_valid && rx_ready && ewr == gi) begin
               err_flag[gi] <= |rx_err;
            end else if (pop && erd == gi) begin
               err_flag[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   assign fifo_err = |err_flag;

   // interrupt sources
   assign rx_lvl = fifo_mode ? (rx_count >= trig) : fifo_valid;
   assign ls_src = fifo_valid && (|top_err);
   assign ms_src = |modem_status[3:0];
   assign tx_cond = fifo_mode ? (tx_fifo_empty && tx_hold_empty) : tx_hold_empty;

   // transmit-empty interrupt pends on the rising empty condition
   always @(posedge clk) begin
      if (rst) begin
         tx_pend <= 1'b0;
         tx_empty_q <= 1'b0;
      end else begin
         tx_empty_q <= tx_cond;
         if (tx_cond && !tx_empty_q) begin
            tx_pend <= 1'b1;
         end else if (!tx_cond) begin
            tx_pend <= 1'b0;
         end else if (rd_hit && addr == `UIE_ADDR_IDENT && ident == `UIE_ID_TX) begin
            tx_pend <= 1'b0;
         end else if (wr_stb && gen_access && addr == `UIE_ADDR_DATA) begin
            tx_pend <= 1'b0;
         end
      end
   end

   // identification priority: line status, receive, transmit, modem
   always @* begin
      if (interrupt_source_mask[`UIE_MASK_LS] && ls_src) begin
         ident = `UIE_ID_LS;
      end else if (interrupt_source_mask[`UIE_MASK_RX] && rx_lvl) begin
         ident = `UIE_ID_RX;
      end else if (interrupt_source_mask[`UIE_MASK_TX] && tx_pend) begin
         ident = `UIE_ID_TX;
      end else if (interrupt_source_mask[`UIE_MASK_MS] && ms_src) begin
         ident = `UIE_ID_MS;
      end else begin
         ident = `UIE_ID_NONE;
      end
   end

   // line status assembly
   always @* begin
      line_stat[0] = fifo_valid;
      line_stat[4:1] = fifo_valid ? top_err : 4'h0;
      line_stat[5] = fifo_mode ? tx_fifo_empty : tx_hold_empty;
      line_stat[6] = tx_fifo_empty && tx_hold_empty && tx_shift_empty;
      line_stat[7] = fifo_mode && fifo_err;
   end

   // register writes
   always @(posedge clk) begin
      if (rst) begin
         interrupt_source_mask <= 4'h0;
         fifo_control_register <= `UIE_FCTL_RESET;
         line_control_register <= `UIE_LCTL_RESET;
      end else if (wr_stb && !cs_n) begin
         if (addr == `UIE_ADDR_LCTL) begin
            line_control_register <= wr_data;
         end else if (gen_access && addr == `UIE_ADDR_MASK) begin
            interrupt_source_mask <= wr_data[3:0];
         end else if (gen_access && addr == `UIE_ADDR_IDENT) begin
            // reset bits self-clear; bits 5-4 unused
            fifo_control_register <= {wr_data[7:6], 2'h0, wr_data[3], 2'h0, wr_data[0]};
         end
      end
   end

   // read data, registered
   always @(posedge clk) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_hit) begin
         case (addr)
            `UIE_ADDR_DATA: rd_data <= fifo_out[7:0];
            `UIE_ADDR_MASK: rd_data <= {4'h0, interrupt_source_mask};
            `UIE_ADDR_IDENT: rd_data <= {{2{fifo_mode}}, 2'h0, ident};
            `UIE_ADDR_LCTL: rd_data <= line_control_register;
            `UIE_ADDR_LINE: rd_data <= line_stat;
            `UIE_ADDR_MODEM: rd_data <= modem_status;
            default: rd_data <= 8'h00;
         endcase
      end
   end

   // dma ready strobes and interrupt pin
   always @(posedge clk) begin
      if (rst) begin
         channel_irq <= 1'b0;
         transmit_ready_n <= 1'b0;
         multi_function_pin <= 1'b1;
         rx_rdy_latch <= 1'b0;
      end else begin
         channel_irq <= (ident != `UIE_ID_NONE);
         if (dma_mode1) begin
            transmit_ready_n <= tx_fifo_full;
            // asserts at trigger, holds until fifo empties
            if (rx_count >= trig) begin
               rx_rdy_latch <= 1'b1;
            end else if (!fifo_valid) begin
               rx_rdy_latch <= 1'b0;
            end
         end else begin
            transmit_ready_n <= fifo_mode ? !tx_fifo_empty : !tx_hold_empty;
            rx_rdy_latch <= fifo_valid;
         end
         multi_function_pin <= rx_mf_mode ? !(dma_mode1 ? (rx_rdy_latch || rx_count >= trig)
            : fifo_valid) : 1'b1;
      end
   end
endmodule // uie_channel
`default_nettype wire

// [test/uie_channel_asserts.sv]
// checker: register readback, interrupt and ready timing of one channel
// assumes bind onto uie_channel; shadows divisor access from line control writes
`timescale 1ns/1ps
`default_nettype none
`include "uie_consts.vh"
module uie_channel_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host bus
   input wire logic cs_n,
   input wire logic [2:0] addr,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   // engine and outputs
   input wire logic tx_fifo_empty,
   input wire logic tx_fifo_full,
   input wire logic tx_hold_empty,
   input wire logic tx_shift_empty,
   input wire logic [7:0] modem_status,
   input wire logic channel_irq,
   input wire logic transmit_ready_n
);
   // shadows of host writes; run skips the first edge after reset
   logic [7:0] mask;
   logic [7:0] fctl;
   logic dlab;
   logic run;
   always_ff @(posedge clk) begin
      run <= !rst;
      if (rst) begin
         mask <= 8'h00;
         fctl <= 8'h00;
         dlab <= 1'h0;
      end else if (wr_stb && !cs_n) begin
         if (addr == `UIE_ADDR_LCTL)
            dlab <= wr_data[7];
         if (!dlab && addr == `UIE_ADDR_MASK)
            mask <= wr_data;
         if (!dlab && addr == `UIE_ADDR_IDENT)
            fctl <= wr_data;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_at(logic [2:0] a);
      rd_stb && !cs_n && !dlab && addr == a;
   endsequence
   AST_MASK_RD: assert property (rd_at(`UIE_ADDR_MASK) |=> rd_data == {4'h0, $past(mask[3:0])})
      else $error("mask readback wrong");
   AST_LINE_EMPTY: assert property (rd_at(`UIE_ADDR_LINE) |=>
      rd_data[6] == $past(tx_fifo_empty && tx_hold_empty && tx_shift_empty))
      else $error("line bit 6 wrong");
   AST_LINE_THR: assert property (rd_at(`UIE_ADDR_LINE) ##0 fctl[0] |=>
      rd_data[5] == $past(tx_fifo_empty)) else $error("line bit 5 wrong");
   AST_ID_FIFO: assert property (rd_at(`UIE_ADDR_IDENT) |=>
      rd_data[7:6] == {2{$past(fctl[0])}}) else $error("ident fifo bits wrong");
   AST_NO_IRQ: assert property (run && mask[3:0] == 4'h0 |=> !channel_irq)
      else $error("interrupt with mask clear");
   AST_MODEM: assert property (run && mask[3] && |modem_status[3:0] |=> channel_irq)
      else $error("modem interrupt missing");
   AST_TXR0: assert property (run && !(fctl[0] && fctl[3]) |=>
      transmit_ready_n == !$past(fctl[0] ? tx_fifo_empty : tx_hold_empty))
      else $error("mode 0 transmit ready wrong");
   AST_TXR1: assert property (run && fctl[0] && fctl[3] |=>
      transmit_ready_n == $past(tx_fifo_full)) else $error("mode 1 transmit ready wrong");
   AST_DLAB_RD: assert property (rd_stb && !cs_n && dlab && addr != `UIE_ADDR_LCTL |=>
      $stable(rd_data)) else $error("read taken with divisor access set");
endmodule // uie_channel_asserts
bind uie_channel uie_channel_asserts uie_channel_asserts_i (.clk(clk), .rst(rst), .cs_n(cs_n),
   .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data),
   .tx_fifo_empty(tx_fifo_empty), .tx_fifo_full(tx_fifo_full), .tx_hold_empty(tx_hold_empty),
   .tx_shift_empty(tx_shift_empty), .modem_status(modem_status), .channel_irq(channel_irq),
   .transmit_ready_n(transmit_ready_n));
`default_nettype wire

// [test/uie_engine_model.sv]
// serial engine stand-in: offers received characters on valid/ready
// assumes the bench calls send and clk is the channel clock
`timescale 1ns/1ps
`default_nettype none
module uie_engine_model (
   // clock
   input wire logic clk,
   // receive stream
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_char,
   output logic [3:0] rx_err
);
   initial begin
      rx_valid = 1'h0;
      rx_char = 8'h00;
      rx_err = 4'h0;
   end
   // n characters back to back, each held until taken
   task automatic send(input int n, input logic [7:0] ch, input logic [3:0] er);
      @(negedge clk);
      for (int i = 0; i < n; i++) begin
         rx_valid = 1'h1;
         rx_char = ch + i[7:0];
         rx_err = er;
         while (rx_ready !== 1'h1)
            @(negedge clk);
         @(negedge clk);
      end
      rx_valid = 1'h0;
      // released lines must not echo the last character
      rx_char = ~rx_char;
      rx_err = ~rx_err;
   endtask
endmodule // uie_engine_model
`default_nettype wire

// [test/uie_channel_tb_top.sv]
// bench: register calls and stream pushes with expected results
// assumes uie_channel with bound checker and the engine model
`timescale 1ns/1ps
`default_nettype none
`include "uie_consts.vh"
module uie_channel_tb_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic cs_n = 1'h1;
   logic [2:0] addr = 3'h0;
   logic wr_stb = 1'h0;
   logic rd_stb = 1'h0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] modem_status = 8'h00;
   logic rx_mf_mode = 1'h0;
   logic tx_fifo_full = 1'h0;
   logic tx_hold_empty = 1'h1;
   logic tx_fifo_empty = 1'h1;
   logic tx_shift_empty = 1'h1;
   logic [7:0] v;
   wire [7:0] rd_data;
   wire [7:0] rx_char;
   wire [3:0] rx_err;
   wire rx_valid, rx_ready, channel_irq, transmit_ready_n, multi_function_pin;
   int failures = 0;
   int checks = 0;
   always #25 clk = ~clk;
   uie_channel uie_channel_i (.clk(clk), .rst(rst), .cs_n(cs_n), .addr(addr), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_char(rx_char), .rx_err(rx_err), .tx_fifo_empty(tx_fifo_empty),
      .tx_fifo_full(tx_fifo_full), .tx_hold_empty(tx_hold_empty),
      .tx_shift_empty(tx_shift_empty),
      .modem_status(modem_status), .rx_mf_mode(rx_mf_mode), .channel_irq(channel_irq),
      .transmit_ready_n(transmit_ready_n), .multi_function_pin(multi_function_pin));
   uie_engine_model uie_engine_model_i (.clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_char(rx_char), .rx_err(rx_err));
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      cs_n = 1'h0;
      addr = a;
      wr_data = d;
      wr_stb = w;
      rd_stb = !w;
      @(negedge clk);
      wr_stb = 1'h0;
      rd_stb = 1'h0;
      cs_n = 1'h1;
      v = rd_data;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chkb(input string what, input logic exp, input logic got);
      chk(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
      acc(1'h0, a, 8'h00);
      chk(what, exp, v);
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      rdc(`UIE_ADDR_MASK, 8'h00, "mask");
      rdc(`UIE_ADDR_LINE, 8'h60, "line");
      rdc(`UIE_ADDR_IDENT, 8'h01, "ident");
      rdc(3'h7, 8'h00, "unmapped");
      acc(1'h1, `UIE_ADDR_MASK, 8'hff);
      rdc(`UIE_ADDR_MASK, 8'h0f, "mask");
      acc(1'h1, `UIE_ADDR_LCTL, 8'h80);
      acc(1'h1, `UIE_ADDR_MASK, 8'h05);
      rdc(`UIE_ADDR_LCTL, 8'h80, "line control");
      rdc(`UIE_ADDR_MASK, 8'h80, "refused read");
      acc(1'h1, `UIE_ADDR_LCTL, 8'h00);
      rdc(`UIE_ADDR_MASK, 8'h0f, "mask");
      $display("test registers done");
      acc(1'h1, `UIE_ADDR_MASK, 8'h08);
      modem_status = 8'h01;
      repeat (2) @(negedge clk);
      chkb("irq", 1'h1, channel_irq);
      rdc(`UIE_ADDR_IDENT, 8'h00, "ident");
      modem_status = 8'h00;
      acc(1'h1, `UIE_ADDR_MASK, 8'h00);
      repeat (2) @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      $display("test modem done");
      rx_mf_mode = 1'h1;
      acc(1'h1, `UIE_ADDR_MASK, 8'h01);
      uie_engine_model_i.send(1, 8'h5a, 4'h0);
      @(negedge clk);
      chkb("irq", 1'h1, channel_irq);
      chkb("mf pin", 1'h0, multi_function_pin);
      rdc(`UIE_ADDR_IDENT, 8'h04, "ident");
      rdc(`UIE_ADDR_LINE, 8'h61, "line");
      rdc(`UIE_ADDR_DATA, 8'h5a, "data");
      @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      chkb("mf pin", 1'h1, multi_function_pin);
      $display("test receive done");
      acc(1'h1, `UIE_ADDR_MASK, 8'h02);
      tx_hold_empty = 1'h0;
      repeat (2) @(negedge clk);
      chkb("tx ready", 1'h1, transmit_ready_n);
      tx_hold_empty = 1'h1;
      repeat (2) @(negedge clk);
      chkb("irq", 1'h1, channel_irq);
      rdc(`UIE_ADDR_IDENT, 8'h02, "ident");
      @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      tx_hold_empty = 1'h0;
      @(negedge clk);
      tx_hold_empty = 1'h1;
      acc(1'h1, `UIE_ADDR_DATA, 8'h33);
      @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      $display("test transmit done");
      acc(1'h1, `UIE_ADDR_IDENT, 8'h01);
      acc(1'h1, `UIE_ADDR_MASK, 8'h04);
      uie_engine_model_i.send(1, 8'h11, 4'h2);
      @(negedge clk);
      chkb("irq", 1'h1, channel_irq);
      rdc(`UIE_ADDR_LINE, 8'he5, "line");
      rdc(`UIE_ADDR_DATA, 8'h11, "data");
      rdc(`UIE_ADDR_LINE, 8'h60, "line");
      chkb("irq", 1'h0, channel_irq);
      $display("test line error done");
      acc(1'h1, `UIE_ADDR_MASK, 8'h02);
      tx_fifo_empty = 1'h0;
      tx_shift_empty = 1'h0;
      repeat (2) @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      chkb("tx ready", 1'h1, transmit_ready_n);
      rdc(`UIE_ADDR_LINE, 8'h00, "line");
      tx_fifo_empty = 1'h1;
      repeat (2) @(negedge clk);
      chkb("irq", 1'h1, channel_irq);
      rdc(`UIE_ADDR_LINE, 8'h20, "line");
      rdc(`UIE_ADDR_IDENT, 8'hc2, "ident");
      acc(1'h1, `UIE_ADDR_MASK, 8'h00);
      tx_shift_empty = 1'h1;
      repeat (2) @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      $display("test transmit fifo done");
      acc(1'h1, `UIE_ADDR_IDENT, 8'h49);
      acc(1'h1, `UIE_ADDR_MASK, 8'h01);
      uie_engine_model_i.send(1, 8'h20, 4'h0);
      @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      chkb("mf pin", 1'h1, multi_function_pin);
      uie_engine_model_i.send(1, 8'h21, 4'h0);
      @(negedge clk);
      chkb("irq", 1'h1, channel_irq);
      chkb("mf pin", 1'h0, multi_function_pin);
      rdc(`UIE_ADDR_IDENT, 8'hc4, "ident");
      rdc(`UIE_ADDR_DATA, 8'h20, "data");
      @(negedge clk);
      chkb("irq", 1'h0, channel_irq);
      tx_fifo_full = 1'h1;
      uie_engine_model_i.send(7, 8'h30, 4'h0);
      chkb("rx ready", 1'h0, rx_ready);
      chkb("tx ready", 1'h1, transmit_ready_n);
      tx_fifo_full = 1'h0;
      acc(1'h1, `UIE_ADDR_IDENT, 8'h4b);
      @(negedge clk);
      rdc(`UIE_ADDR_LINE, 8'h60, "line");
      chkb("mf pin", 1'h1, multi_function_pin);
      $display("test dma block done");
      close_out;
   end
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      close_out;
   end
endmodule // uie_channel_tb_top
`default_nettype wire
